// >>> inc/fifo_level_pkg.sv
// Purpose: constants for the fifo occupancy and feature control registers
// Assumes: byte-wide host register port, registers at printed offsets
// Notes:   one uart channel
package fifo_level_pkg;
    localparam logic [7:0] special_access_value = 8'hBF;
    localparam logic [2:0] occupancy_offset     = 3'h0;
    localparam logic [2:0] feature_offset       = 3'h1;
    localparam logic [7:0] feature_reset        = 8'h20;
    localparam logic [7:0] occupancy_reset      = 8'h00;
    localparam int         table_sel_lsb        = 4;
    localparam int         table_sel_msb        = 5;
    localparam int         hyst_msb             = 3;
    localparam int         fifo_depth           = 64;
    localparam int         count_width          = 7;
    localparam logic       sel_receive          = 1'b0;
    localparam logic       sel_transmit         = 1'b1;
    typedef enum logic [1:0]
    {
        table_a_type_val = 2'b00,
        table_b_type_val = 2'b01,
        table_c_type_val = 2'b10,
        table_d_type_val = 2'b11
    } trigger_table_type;
endpackage

// >>> design/fifo_fill_counter.sv
// Purpose: live fill count of one fifo from push and pop strobes
// Assumes: push and pop are one-cycle pulses on clk_sys
// Notes:   saturates at depth and at zero
`timescale 1ns/10ps
module fifo_fill_counter
    import fifo_level_pkg::*;
#(
    parameter int depth = fifo_depth
)
(
    input  wire logic                   clk_sys,
    input  wire logic                   sys_rst,
    input  wire logic                   push,
    input  wire logic                   pop,
    output logic [count_width-1:0]      fill
);
    localparam logic [count_width-1:0] full_level = count_width'(depth);
    logic [count_width-1:0] fill_q;
    logic [count_width-1:0] fill_d;
    wire inc = push && !pop && (fill_q != full_level);
    wire dec = pop && !push && (fill_q != '0);
    // ----------------------------------------
    // counter
    // ----------------------------------------
    // a push refused while full is simply lost, as the fifo drops it too
    assign fill_d = inc ? fill_q + 7'h01 :
                    dec ? fill_q - 7'h01 : fill_q;
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            fill_q <= '0;
        else
            fill_q <= fill_d;
    end
    assign fill = fill_q;
endmodule

// >>> design/fifo_level_feature_regs.sv
// Purpose: occupancy counter and feature control registers of one channel
// Assumes: host port is byte wide, rd_strobe and wr_strobe last one cycle
// Notes:   reads return registered data one cycle after rd_strobe
//
// Functional notes
// - bit 7 of the occupancy register shows the fifo counted: 0 rx, 1 tx.
// - each host read of the occupancy register swaps rx and tx reporting.
// - bits 6:0 of the occupancy register hold the selected fifo's count.
// - feature control at 01H resets to 20H, bits 7:6 read 0, needs BFH.
// - feature control bits 5:4 pick trigger table a to d for both fifos.
// - occupancy register at 00H is reachable only with line control BFH.
`timescale 1ns/10ps
module fifo_level_feature_regs
    import fifo_level_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [7:0]       line_control,
    input  wire logic [2:0]       addr,
    input  wire logic             rd_strobe,
    input  wire logic             wr_strobe,
    input  wire logic [7:0]       wr_data,
    output logic [7:0]            rd_data,
    output logic                  rd_hit,
    input  wire logic             rx_push,
    input  wire logic             rx_pop,
    input  wire logic             tx_push,
    input  wire logic             tx_pop,
    output trigger_table_type     trigger_table,
    output logic [3:0]            hysteresis_sel
);
    // ----------------------------------------
    // local sizes
    // ----------------------------------------
    // slot 0 counts the receive fifo and slot 1 the transmit fifo, so a
    // slot number is the same value as the select bit that is reported
    localparam int fifo_count = 2;
    localparam int rx_slot    = 0;
    localparam int tx_slot    = 1;
    localparam int reg_width  = 8;

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [7:0]             feature_q;
    logic                   sel_q;
    logic                   sel_d;
    logic [7:0]             rd_data_q;
    logic [7:0]             rd_data_d;
    logic                   rd_hit_q;
    logic                   rd_hit_d;

    // ----------------------------------------
    // fill counter wiring
    // ----------------------------------------
    logic [fifo_count-1:0]  push_vec;
    logic [fifo_count-1:0]  pop_vec;
    wire  [count_width-1:0] fill_vec [fifo_count];
    logic [count_width-1:0] rx_fill;
    logic [count_width-1:0] tx_fill;
    logic [count_width-1:0] sel_fill;

    // ----------------------------------------
    // decode wires
    // ----------------------------------------
    logic                   special;
    logic                   addr_occ;
    logic                   addr_feat;
    logic                   occ_hit;
    logic                   feat_hit;
    logic                   occ_read;
    logic                   feat_read;
    logic                   feat_write;
    logic                   any_read;

    // ----------------------------------------
    // read and write words
    // ----------------------------------------
    wire  [7:0]             feature_d;
    logic [7:0]             occ_word;
    logic [7:0]             feat_word;
    logic [7:0]             idle_word;
    logic [table_sel_msb-table_sel_lsb:0] table_field;
    logic [hyst_msb:0]      hyst_field;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    // every access needs the special line control value first; without it
    // these offsets belong to the ordinary registers of the channel
    assign special    = (line_control == special_access_value);
    assign addr_occ   = (addr == occupancy_offset);
    assign addr_feat  = (addr == feature_offset);
    assign occ_hit    = special && addr_occ;
    assign feat_hit   = special && addr_feat;
    assign occ_read   = rd_strobe && occ_hit;
    assign feat_read  = rd_strobe && feat_hit;
    assign feat_write = wr_strobe && feat_hit;
    assign any_read   = occ_read || feat_read;

    // ----------------------------------------
    // fill counters
    // ----------------------------------------
    // one counter per fifo; a push and a pop in one cycle cancel out
    assign push_vec = {tx_push, rx_push};
    assign pop_vec  = {tx_pop, rx_pop};

    for (genvar f = 0; f < fifo_count; f++)
    begin : fill_slot
        fifo_fill_counter #(.depth(fifo_depth)) i_fifo_fill_counter
        (
            .clk_sys (clk_sys),
            .sys_rst (sys_rst),
            .push    (push_vec[f]),
            .pop     (pop_vec[f]),
            .fill    (fill_vec[f])
        );
    end

    assign rx_fill = fill_vec[rx_slot];
    assign tx_fill = fill_vec[tx_slot];

    // ----------------------------------------
    // fifo select
    // ----------------------------------------
    // the swap takes effect after the read, so this read shows the old side
    assign sel_d    = occ_read ? ~sel_q : sel_q;
    assign sel_fill = (sel_q == sel_transmit) ? tx_fill : rx_fill;

    // ----------------------------------------
    // feature control bits
    // ----------------------------------------
    // reserved bits are tied low rather than stored, so no write can make
    // them read back as one
    for (genvar b = 0; b < reg_width; b++)
    begin : feature_bit
        if (b <= table_sel_msb)
        begin : writable
            assign feature_d[b] = feat_write ? wr_data[b] : feature_q[b];
        end
        else
        begin : reserved
            assign feature_d[b] = 1'b0;
        end
    end

    // ----------------------------------------
    // read words
    // ----------------------------------------
    // only one register answers a read, so the order of the arms below
    // never changes what the host sees
    assign occ_word  = {sel_q, sel_fill};
    assign feat_word = feature_q;
    // a refused or idle read gives zero so the host bus sees no stale data
    assign idle_word = 8'h00;
    assign rd_data_d = occ_read  ? occ_word  :
                       feat_read ? feat_word : idle_word;
    assign rd_hit_d  = any_read;

    // ----------------------------------------
    // feature register
    // ----------------------------------------
    // writes outside the special access window never reach this flop
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            feature_q <= feature_reset;
        else
            feature_q <= feature_d;
    end

    // ----------------------------------------
    // select register
    // ----------------------------------------
    // every reset starts the host on the receive side, so software that
    // loses track can recover only by a reset or by reading bit 7
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            sel_q <= sel_receive;
        else
            sel_q <= sel_d;
    end

    // ----------------------------------------
    // read data register
    // ----------------------------------------
    // read data stands one cycle and then drops back to zero
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            rd_data_q <= occupancy_reset;
        else
            rd_data_q <= rd_data_d;
    end

    // ----------------------------------------
    // read hit register
    // ----------------------------------------
    // rd_hit marks only reads that land here, so the channel's read mux
    // can pick this block's data without decoding the offset again
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            rd_hit_q <= 1'b0;
        else
            rd_hit_q <= rd_hit_d;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // the trigger tables themselves live with the fifos; only the choice
    // of table and of hysteresis leaves this block
    assign table_field    = feature_q[table_sel_msb:table_sel_lsb];
    assign hyst_field     = feature_q[hyst_msb:0];
    assign trigger_table  = trigger_table_type'(table_field);
    assign hysteresis_sel = hyst_field;
    assign rd_data        = rd_data_q;
    assign rd_hit         = rd_hit_q;
endmodule

// >>> verification/fifo_level_feature_regs_sva.sv
// Purpose: assertions on the occupancy and feature registers
// Assumes: one clock, synchronous reset
// Notes:   rx/tx select is tracked here to judge each swap
`timescale 1ns/10ps
module fifo_level_feature_regs_sva
    import fifo_level_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              sys_rst,
    input wire logic [7:0]        line_control,
    input wire logic [2:0]        addr,
    input wire logic              rd_strobe,
    input wire logic              wr_strobe,
    input wire logic [7:0]        wr_data,
    input wire logic [7:0]        rd_data,
    input wire logic              rd_hit,
    input wire trigger_table_type trigger_table
);
default clocking @(posedge clk_sys); endclocking
default disable iff (sys_rst);
logic       open_w;
logic       wr_feat_w;
logic [1:0] wr_sel_w;
logic       sel_q;
assign open_w    = line_control == special_access_value;
assign wr_feat_w = wr_strobe && open_w && addr == feature_offset;
assign wr_sel_w  = wr_data[5:4];
// a refused read must not swap, so the tracker mirrors the gate
always_ff @(posedge clk_sys)
    if (sys_rst)
        sel_q <= sel_receive;
    else if (rd_strobe && open_w && addr == occupancy_offset)
        sel_q <= !sel_q;
a_read_answered:
    assert property (rd_strobe && open_w && addr < 3'h2 |=> rd_hit)
    else $error("hit read gave no rd_hit");
a_read_refused:
    assert property (rd_strobe && !(open_w && addr < 3'h2)
        |=> !rd_hit && rd_data == 8'h00) else $error("refused read answered");
a_rsvd_zero:
    assert property (rd_hit && $past(addr) == feature_offset
        |-> rd_data[7:6] == 2'b00) else $error("reserved bits not zero");
a_sel_swap:
    assert property (rd_hit && $past(addr) == occupancy_offset
        |-> rd_data[7] == !sel_q) else $error("fifo select wrong");
a_count_max:
    assert property (rd_hit && $past(addr) == occupancy_offset
        |-> rd_data[6:0] <= 7'h40) else $error("count above depth");
a_table_write:
    assert property (wr_feat_w |=> trigger_table == $past(wr_sel_w))
    else $error("table not written");
a_table_hold:
    assert property (!wr_feat_w |=> $stable(trigger_table))
    else $error("table changed without write");
endmodule
bind fifo_level_feature_regs fifo_level_feature_regs_sva i_sva (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .line_control(line_control),
    .addr(addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit),
    .trigger_table(trigger_table));

// >>> verification/tb_top.sv
// Purpose: directed test of the occupancy and feature registers
// Assumes: inputs change 1 ns after the rising edge
// Notes:   fill counts come from push and pop pulses
`timescale 1ns/10ps
module tb_top
    import fifo_level_pkg::*;
;
logic              clk_sys, sys_rst, rd_strobe, wr_strobe, rd_hit;
logic [7:0]        line_control, wr_data, rd_data;
logic [2:0]        addr;
logic [3:0]        fifo_ev, hysteresis_sel;
trigger_table_type trigger_table;
int                error_cnt, check_count;
fifo_level_feature_regs i_fifo_level_feature_regs (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .line_control(line_control), .addr(addr),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data),
    .rd_data(rd_data), .rd_hit(rd_hit), .rx_push(fifo_ev[3]),
    .rx_pop(fifo_ev[2]), .tx_push(fifo_ev[1]), .tx_pop(fifo_ev[0]),
    .trigger_table(trigger_table), .hysteresis_sel(hysteresis_sel));
task chk(string what, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
        error_cnt++;
        $display("BAD %s exp %h got %h", what, exp, got);
    end
endtask
task rd(logic [2:0] a, logic [7:0] exp, logic hit);
    @(posedge clk_sys) #1 addr = a;
    rd_strobe = 1'b1;
    @(posedge clk_sys) #1 rd_strobe = 1'b0;
    chk("rd_data", exp, rd_data);
    chk("rd_hit", {7'h00, hit}, {7'h00, rd_hit});
endtask
task wr(logic [7:0] d);
    @(posedge clk_sys) #1 addr = feature_offset;
    wr_strobe = 1'b1;
    wr_data = d;
    @(posedge clk_sys) #1 wr_strobe = 1'b0;
endtask
task ev(logic [3:0] v, int n);
    repeat (n) @(posedge clk_sys) #1 fifo_ev = v;
    @(posedge clk_sys) #1 fifo_ev = 4'h0;
endtask
task wrap_up;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
initial
begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
end
// a hang past a generous margin ends the run as a mismatch
initial
begin
    repeat (1000) @(posedge clk_sys);
    error_cnt++;
    wrap_up();
end
initial
begin
    {sys_rst, rd_strobe, wr_strobe, addr, wr_data, fifo_ev} = '0;
    sys_rst = 1'b1;
    line_control = special_access_value;
    repeat (3) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    chk("table", 8'(feature_reset[table_sel_msb:table_sel_lsb]),
        {6'h00, trigger_table});
    chk("hysteresis", 8'(feature_reset[hyst_msb:0]),
        {4'h0, hysteresis_sel});
    rd(feature_offset, feature_reset, 1'b1);
    line_control = 8'h03;
    rd(feature_offset, 8'h00, 1'b0);
    rd(occupancy_offset, 8'h00, 1'b0);
    line_control = special_access_value;
    $display("access test done");
    ev(4'h8, 4);
    ev(4'h4, 1);
    ev(4'h2, 5);
    rd(occupancy_offset, 8'h03, 1'b1);
    rd(occupancy_offset, 8'h85, 1'b1);
    rd(occupancy_offset, 8'h03, 1'b1);
    ev(4'h2, 64);
    rd(occupancy_offset, 8'hC0, 1'b1);
    rd(3'h5, 8'h00, 1'b0);
    $display("count test done");
    for (int i = 0; i < 4; i++)
    begin
        wr({2'b11, i[1:0], ~i[3:0]});
        chk("table", 8'(i), {6'h00, trigger_table});
        chk("hysteresis", {4'h0, ~i[3:0]}, {4'h0, hysteresis_sel});
        rd(feature_offset, {2'b00, i[1:0], ~i[3:0]}, 1'b1);
    end
    line_control = 8'h03;
    wr(8'h00);
    line_control = special_access_value;
    chk("table", 8'h03, {6'h00, trigger_table});
    rd(feature_offset, 8'h3C, 1'b1);
    $display("table test done");
    wrap_up();
end
endmodule
